// ### logic/ees_store.v
// Purpose: Nonvolatile configuration store with SECDED, unlock, program, refresh
// Assumes: Index writes arrive as one-cycle strobes, synchronous to sys_clk
// Notes:   Store array is modelled as registers; program takes a fixed time
`include "ees_map.vh"

// Overview of operation
// - Refresh code reloads shadows from store
// - Store failure sets fault flag bit seven
// - Words are 16 bits with SECDED
// - Check bits at power-of-two positions
// - Check bit k covers positions with bit k
// - Syndrome points at bit to invert
// - Double error keeps shadow word unchanged
// - Program and refresh need prior unlock
module ees_store (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rst_n,
	// Shadow word write port
	input  wire        shadow_wr,
	input  wire [2:0]  shadow_addr,
	input  wire [15:0] shadow_wdata,
	// Command byte write to the command index
	input  wire        cmd_wr,
	input  wire [3:0]  cmd_index,
	input  wire [7:0]  cmd_code,
	// Health flag read at index one
	input  wire        health_rd,
	output reg  [7:0]  health_flags,
	// Shadow readback
	input  wire [2:0]  rd_addr,
	output reg  [15:0] rd_data,
	// Status
	output wire        busy,
	output reg         unlocked,
	output reg         corrected,
	// Fault injection into stored words, for test of the store itself
	input  wire        inject_wr,
	input  wire [2:0]  inject_addr,
	input  wire [21:0] inject_mask
);

	// Controller states
	localparam ST_IDLE = 2'b00;
	localparam ST_PROG = 2'b01;
	localparam ST_REFR = 2'b10;

	// Sequencer state, program timer and the word pointer both phases walk
	reg [1:0]  state;
	reg [1:0]  next_state;
	reg [31:0] timer;
	reg [2:0]  idx;
	reg [2:0]  next_idx;

	// Host-visible shadow words and the protected store behind them
	reg [15:0] shadow [0:7];
	reg [21:0] store  [0:7];

	// Codec results and command decode
	wire [21:0] enc_code;
	wire [15:0] dec_data;
	wire        dec_single;
	wire        dec_double;
	wire        is_cmd;
	wire        take_cmd;
	wire        go_prog;
	wire        go_refr;
	wire        last_word;
	wire        host_access;

	// True when a command byte carries the wanted code
	function code_hit;
		input [7:0] code;
		input [7:0] want;
		begin
			code_hit = (code == want);
		end
	endfunction

	// Encode the word under program, decode the word under refresh
	ees_secded u_codec (
		.enc_data   (shadow[idx]),
		.enc_code   (enc_code),
		.dec_code   (store[idx]),
		.dec_data   (dec_data),
		.dec_single (dec_single),
		.dec_double (dec_double)
	);

	// Commands are taken only while idle, so a busy store neither acts nor relocks
	assign is_cmd      = cmd_wr && (cmd_index == `EES_CMD_INDEX);
	assign take_cmd    = is_cmd && (state == ST_IDLE);
	assign go_prog     = take_cmd && unlocked && code_hit(cmd_code, `EES_CODE_PROGRAM);
	assign go_refr     = take_cmd && unlocked && code_hit(cmd_code, `EES_CODE_REFRESH);
	assign last_word   = (idx == `EES_LAST_WORD);
	assign host_access = (state == ST_IDLE);
	assign busy        = !host_access;

	// Next state: program holds for the full write time, refresh visits each word once
	always @* begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (go_prog)
					next_state = ST_PROG;
				else if (go_refr)
					next_state = ST_REFR;
			end
			ST_PROG: begin
				if (timer == 32'h0000_0000)
					next_state = ST_IDLE;
			end
			ST_REFR: begin
				if (last_word)
					next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// Word pointer: parked at zero while idle, one step per cycle while busy
	// During the long program it wraps and rewrites the same codewords, which is harmless
	always @* begin
		if (host_access)
			next_idx = 3'h0;
		else
			next_idx = idx + 3'h1;
	end

	// State and word pointer registers
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			idx   <= 3'h0;
		end else begin
			state <= next_state;
			idx   <= next_idx;
		end
	end

	// Program timer: reloaded while idle, counts down to zero while programming
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer <= 32'h0000_0000;
		end else if (host_access) begin
			timer <= `EES_PROG_LOAD;
		end else if (state == ST_PROG && timer != 32'h0000_0000) begin
			timer <= timer - 32'h0000_0001;
		end
	end

	// Unlock latch: set by the unlock code, cleared by any other command code taken after it
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			unlocked <= 1'b0;
		end else if (take_cmd) begin
			unlocked <= code_hit(cmd_code, `EES_CODE_UNLOCK);
		end
	end

	// Protected store: program writes one codeword per cycle, inject flips bits for test
	// The model clears it at reset so that every word starts as a valid zero codeword
	integer j;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (j = 0; j < 8; j = j + 1) begin
				store[j] <= `EES_CODE_RESET;
			end
		end else if (state == ST_PROG) begin
			store[idx] <= enc_code;
		end else if (host_access && inject_wr) begin
			store[inject_addr] <= store[inject_addr] ^ inject_mask;
		end
	end

	// Shadow words: host writes while idle, refresh reloads the corrected contents
	// A word with a double error keeps its old value instead of taking bad data
	integer w;
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (w = 0; w < 8; w = w + 1) begin
				shadow[w] <= `EES_WORD_RESET;
			end
		end else if (host_access && shadow_wr) begin
			shadow[shadow_addr] <= shadow_wdata;
		end else if (state == ST_REFR && !dec_double) begin
			shadow[idx] <= dec_data;
		end
	end

	// Sticky flag: a refresh repaired at least one single-bit error
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			corrected <= 1'b0;
		end else if (state == ST_REFR && dec_single) begin
			corrected <= 1'b1;
		end
	end

	// Health flags: fault set on double error, cleared by read, set wins
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			health_flags <= `EES_HEALTH_RESET;
		end else if (state == ST_REFR && dec_double) begin
			health_flags[`EES_FAULT_BIT] <= 1'b1;
		end else if (health_rd) begin
			health_flags <= `EES_HEALTH_RESET;
		end
	end

	// Registered shadow readback
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			rd_data <= 16'h0000;
		else
			rd_data <= shadow[rd_addr];
	end

endmodule

// ### logic/ees_map.vh
// Purpose: Constants for the nonvolatile configuration store block
// Assumes: 200 MHz system clock
// Notes:   Included by the store controller and its SECDED codec
`ifndef EES_MAP_VH
`define EES_MAP_VH

// Command index and command codes
`define EES_CMD_INDEX      4'hF
`define EES_CODE_UNLOCK    8'h29
`define EES_CODE_PROGRAM   8'hD6
`define EES_CODE_REFRESH   8'h73

// Health flag layout
`define EES_FAULT_BIT      7
`define EES_HEALTH_INDEX   4'h1
`define EES_HEALTH_RESET   8'h00

// Word geometry
`define EES_DATA_W         16
`define EES_CODE_W         22
`define EES_WORDS          8
`define EES_ADDR_W         3

// Last word index and reset contents of shadows and store
`define EES_LAST_WORD      3'h7
`define EES_WORD_RESET     16'h0000
`define EES_CODE_RESET     22'h000000

// Program time in microseconds and cycles at 200 MHz
`define EES_PROG_US        25000
`define EES_CLK_MHZ        200
`define EES_PROG_CYC       (`EES_PROG_US * `EES_CLK_MHZ)
`define EES_PROG_LOAD      (`EES_PROG_CYC - 1)

`endif

// ### logic/ees_secded.v
// Purpose: SECDED encoder and decoder for one 16-bit stored word
// Assumes: Purely combinational, used by the store controller
// Notes:   Codeword bit 0 is overall parity, bits 1..21 are Hamming positions
`include "ees_map.vh"

module ees_secded (
	// Encoder side
	input  wire [15:0] enc_data,
	output reg  [21:0] enc_code,
	// Decoder side
	input  wire [21:0] dec_code,
	output reg  [15:0] dec_data,
	output reg         dec_single,
	output reg         dec_double
);

	// Position of data bit i within the 21-position codeword
	function [4:0] data_pos;
		input integer i;
		integer p;
		integer n;
		begin
			n = 0;
			data_pos = 5'h00;
			for (p = 1; p <= 21; p = p + 1) begin
				if ((p & (p - 1)) != 0) begin
					if (n == i)
						data_pos = p[4:0];
					n = n + 1;
				end
			end
		end
	endfunction

	// Loop counters, one pair per process so neither process drives the other's
	integer ei;
	integer ek;
	integer di;
	integer dk;
	reg [21:1] pos;
	reg [21:1] fix;
	reg [4:0]  syn;
	reg        ovr;

	// Encoder: place data, then check bits, then overall parity
	always @* begin
		pos = 21'h000000;
		for (ei = 0; ei < 16; ei = ei + 1)
			pos[data_pos(ei)] = enc_data[ei];
		for (ek = 0; ek < 5; ek = ek + 1) begin
			for (ei = 1; ei <= 21; ei = ei + 1)
				if (((ei >> ek) & 1) == 1 && ei != (1 << ek))
					pos[1 << ek] = pos[1 << ek] ^ pos[ei];
		end
		enc_code = {pos, ^pos};
	end

	// Decoder: syndrome, overall parity, correction
	always @* begin
		fix = dec_code[21:1];
		syn = 5'h00;
		for (dk = 0; dk < 5; dk = dk + 1)
			for (di = 1; di <= 21; di = di + 1)
				if (((di >> dk) & 1) == 1)
					syn[dk] = syn[dk] ^ fix[di];
		ovr = ^dec_code;
		dec_single = (syn != 5'h00) && ovr;
		dec_double = (syn != 5'h00) && !ovr;
		if (dec_single && syn <= 5'h15)
			fix[syn] = ~fix[syn];
		for (di = 0; di < 16; di = di + 1)
			dec_data[di] = fix[data_pos(di)];
	end

endmodule

// ### sim/ees_store_props.sv
// Purpose: Port checks on the store controller
// Assumes: One clock, active-low reset
// Notes:   Bound from the testbench
module ees_store_props (
	// Clock and reset
	input wire       sys_clk,
	input wire       rst_n,
	// Commands and status
	input wire       cmd_wr,
	input wire [3:0] cmd_index,
	input wire [7:0] cmd_code,
	input wire       busy,
	input wire       unlocked,
	input wire       health_rd,
	input wire [7:0] health_flags,
	input wire       corrected
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Command taken at the index while idle
	wire take = cmd_wr && cmd_index == 4'hF && !busy;
	sequence refresh_run;
		busy [*8] ##1 !busy;
	endsequence
	unlock_take_a: assert property (take && cmd_code == 8'h29 |=> unlocked) else $error("unlock");
	relock_a: assert property (take && unlocked |=> !unlocked) else $error("relock");
	no_unlock_a: assert property (take && !unlocked && cmd_code != 8'h29 |=> !busy) else $error("locked");
	refresh_len_a: assert property (take && unlocked && cmd_code == 8'h73 |=> refresh_run) else $error("refresh");
	prog_run_a: assert property (take && unlocked && cmd_code == 8'hD6 |=> busy [*8]) else $error("program");
	flag_clear_a: assert property (health_rd && !busy |=> health_flags == 8'h00) else $error("clear");
	flag_hold_a: assert property (health_flags[7] && !health_rd |=> health_flags[7]) else $error("hold");
	corr_cause_a: assert property ($rose(corrected) |-> $past(busy)) else $error("correct");
endmodule

// ### sim/ees_host.sv
// Purpose: Host model: index writes, health reads, store faults
// Assumes: One-cycle strobes launched at the rising edge
// Notes:   Released data lines show inverted values
module ees_host (
	// Clock
	input wire          sys_clk,
	// Strobes and data
	output logic        cmd_wr,
	output logic [3:0]  index,
	output logic [7:0]  code,
	output logic        shadow_wr,
	output logic        inject_wr,
	output logic        health_rd,
	output logic [2:0]  addr,
	output logic [21:0] val
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle at time zero
	initial {cmd_wr, index, code, shadow_wr, inject_wr, health_rd, addr, val} = '0;
	// Command byte to an index
	task automatic cmd(input logic [3:0] i, input logic [7:0] c);
		@(posedge sys_clk);
		{cmd_wr, index, code} <= {1'b1, i, c};
		@(posedge sys_clk);
		{cmd_wr, code} <= {1'b0, ~c};
	endtask
	// Shadow word or fault mask at an address
	task automatic put(input logic f, input logic [2:0] a, input logic [21:0] v);
		@(posedge sys_clk);
		{inject_wr, shadow_wr, addr, val} <= {f, !f, a, v};
		@(posedge sys_clk);
		{inject_wr, shadow_wr, val} <= {2'b00, ~v};
	endtask
	// Health read clears the flags
	task automatic hrd;
		@(posedge sys_clk);
		health_rd <= 1'b1;
		@(posedge sys_clk);
		health_rd <= 1'b0;
	endtask
	// Readback address, data settled two edges on
	task automatic pick(input logic [2:0] a);
		@(posedge sys_clk);
		addr <= a;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
endmodule

// ### sim/testbench.sv
// Purpose: Self-checking bench for the store controller
// Assumes: 200 MHz clock, reset held 8 cycles
// Notes:   The long program time is cut short by a reset
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Bench state and wires
	logic        sys_clk;
	logic        rst_n;
	integer      miscompares;
	integer      compares;
	wire         cmd_wr, shadow_wr, inject_wr, health_rd, busy, unlocked, corrected;
	wire [3:0]   index;
	wire [7:0]   code, health_flags;
	wire [2:0]   addr;
	wire [15:0]  rd_data;
	wire [21:0]  val;
	ees_host host (.sys_clk(sys_clk), .cmd_wr(cmd_wr), .index(index), .code(code), .shadow_wr(shadow_wr),
		.inject_wr(inject_wr), .health_rd(health_rd), .addr(addr), .val(val));
	ees_store uut (.sys_clk(sys_clk), .rst_n(rst_n), .shadow_wr(shadow_wr), .shadow_addr(addr),
		.shadow_wdata(val[15:0]), .cmd_wr(cmd_wr), .cmd_index(index), .cmd_code(code), .health_rd(health_rd),
		.health_flags(health_flags), .rd_addr(addr), .rd_data(rd_data), .busy(busy), .unlocked(unlocked),
		.corrected(corrected), .inject_wr(inject_wr), .inject_addr(addr), .inject_mask(val));
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Unlock then refresh, wait for idle under a bound
	task automatic refresh;
		host.cmd(4'hF, 8'h29);
		host.cmd(4'hF, 8'h73);
		for (int i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			#1;
			if (busy === 1'b0)
				return;
		end
		miscompares++;
		final_report;
	endtask
	// Locked commands refused, other code relocks
	task automatic t_lock;
		host.cmd(4'hF, 8'hD6);
		host.cmd(4'hF, 8'h73);
		#1;
		chk("busy", busy, 1'b0);
		host.cmd(4'hF, 8'h29);
		#1;
		chk("unlocked", unlocked, 1'b1);
		host.cmd(4'hF, 8'h5A);
		#1;
		chk("unlocked", unlocked, 1'b0);
	endtask
	// Codeword layout and single-bit correction
	task automatic t_code;
		host.put(0, 3'h2, 22'h00BEEF);
		host.put(1, 3'h2, 22'h00000F); // Word 0x0001: parity, P0, P1, D0
		host.put(0, 3'h3, 22'h001234);
		host.put(1, 3'h3, 22'h200000); // Lone flip of D15
		host.put(0, 3'h4, 22'h005555);
		host.put(1, 3'h4, 22'h010000); // Lone flip of P4
		refresh;
		host.pick(3'h2);
		chk("word2", rd_data, 16'h0001);
		host.pick(3'h3);
		chk("word3", rd_data, 16'h0000);
		host.pick(3'h4);
		chk("word4", rd_data, 16'h0000);
		chk("corrected", corrected, 1'b1);
		chk("flags", health_flags, 8'h00);
	endtask
	// Double error keeps the shadow and raises the fault flag
	task automatic t_dbl;
		host.put(0, 3'h5, 22'h00A5A5);
		host.put(1, 3'h5, 22'h000028); // Flips of D0 and D1
		refresh;
		host.pick(3'h5);
		chk("word5", rd_data, 16'hA5A5);
		chk("flags", health_flags, 8'h80);
		host.hrd;
		#1;
		chk("flags", health_flags, 8'h00);
	endtask
	// Program runs after unlock; reset ends the long wait
	task automatic t_prog;
		host.cmd(4'hF, 8'h29);
		host.cmd(4'hF, 8'hD6);
		repeat (10) @(posedge sys_clk);
		#1;
		chk("busy", busy, 1'b1);
		chk("unlocked", unlocked, 1'b0);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk("busy", busy, 1'b0);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		rst_n = 1'b0;
		miscompares = 0;
		compares = 0;
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		t_lock;
		t_code;
		t_dbl;
		t_prog;
		final_report;
	end
endmodule
bind ees_store ees_store_props props (.sys_clk(sys_clk), .rst_n(rst_n), .cmd_wr(cmd_wr), .cmd_index(cmd_index),
	.cmd_code(cmd_code), .busy(busy), .unlocked(unlocked), .health_rd(health_rd), .health_flags(health_flags),
	.corrected(corrected));
